// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
    import group_flags_pkg::*;
    typedef struct {logic [31:0] data; logic err;} note_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, flags = 32'h00000000;
    logic pready, pslverr, tc_select = 1'b0, use_global_limit, dev_en = 1'b0;
    logic cap_config_support = 1'b1, cap_tokens_support = 1'b1, cap_global_support = 1'b1;
    logic [2:0] traffic_class;
    logic [7:0] tokens_allowed, tokens_reserved;
    note_t notes[$];
    note_t cur;
    int errors = 0, checked = 0, seed = 73;
    // Four tokens per engine, one engine in the group
    localparam logic [7:0] MIN_ALLOWED = 8'h04;
    // Device token total, plain default
    localparam logic [7:0] TOTAL_TOKENS = 8'hFF;

    group_flags group_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cap_config_support(cap_config_support), .cap_tokens_support(cap_tokens_support),
        .cap_global_support(cap_global_support), .tc_select(tc_select),
        .traffic_class(traffic_class), .tokens_allowed(tokens_allowed),
        .tokens_reserved(tokens_reserved), .use_global_limit(use_global_limit));

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // ****************************************
    // Reporting
    // ****************************************
    task automatic results;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask // results

    task automatic fail(input string m);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask // fail

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) fail(m);
    endtask // chk

    // Monitor takes the oldest note at every completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) fail("unexpected transfer");
            else begin
                cur = notes.pop_front();
                checked++;
                if (pslverr !== cur.err || (!pwrite && prdata !== cur.data)) fail("bus answer");
            end
        end
    end

    // ****************************************
    // Bus and model tasks
    // ****************************************
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        int n;
        notes.push_back('{ed, ee});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail("no ready");
            results();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask // apb

    // Software side keeps token programming legal for a lone group
    // legal tokens
    function automatic logic [31:0] legal(input logic [31:0] r);
        logic [7:0] al;
        logic [7:0] rs;
        logic [31:0] o;
        al = r[27:20];
        rs = r[15:8];
        if (rs > TOTAL_TOKENS) rs = TOTAL_TOKENS;
        if (al < rs) al = rs;
        if (al < MIN_ALLOWED) al = MIN_ALLOWED;
        if (al > TOTAL_TOKENS) al = TOTAL_TOKENS;
        o = r;
        o[27:20] = al;
        o[15:8] = rs;
        return o;
    endfunction // legal

    // Shadow model keeps only what the locks let through
    task automatic wr_flags(input logic [31:0] d);
        logic [31:0] m;
        d = legal(d);
        m = 32'h00000000;
        if (cap_config_support && !dev_en) begin
            m = 32'h0000003F;
            if (cap_tokens_support) m = m | 32'h0FF0FF00;
            if (cap_global_support) m = m | 32'h00000080;
        end
        flags = (flags & ~m) | (d & m);
        apb(GROUP_FLAGS_ADDR, 1'b1, d, 32'h00000000, 1'b0);
        apb(GROUP_FLAGS_ADDR, 1'b0, 32'h00000000, flags, 1'b0);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(tokens_allowed, cap_tokens_support ? flags[27:20] : 8'h00, "allowed");
        chk(tokens_reserved, cap_tokens_support ? flags[15:8] : 8'h00, "reserved");
        chk(use_global_limit, flags[7] & cap_global_support, "global");
        for (int s = 0; s < 2; s++) begin
            @(posedge pclk);
            tc_select <= s[0];
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk(traffic_class, s ? flags[5:3] : flags[2:0], "class");
        end
    endtask // wr_flags

    task automatic set_caps(input logic c, input logic t, input logic g);
        @(posedge pclk);
        cap_config_support <= c;
        cap_tokens_support <= t;
        cap_global_support <= g;
        repeat (3) @(posedge pclk);
    endtask // set_caps

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(GROUP_FLAGS_ADDR, 1'b0, 32'h00000000, 32'h00000000, 1'b0);
        apb(CAP_STATUS_ADDR, 1'b0, 32'h00000000, 32'h0000000F, 1'b0);
        for (int i = 0; i < 6; i++) wr_flags($random(seed));
        wr_flags(32'hFFFFFFFF);
        // Device enabled locks the group fields
        apb(DEV_CTRL_ADDR, 1'b1, 32'h00000001, 32'h00000000, 1'b0);
        dev_en = 1'b1;
        apb(CAP_STATUS_ADDR, 1'b0, 32'h00000000, 32'h00000007, 1'b0);
        wr_flags(~flags);
        apb(DEV_CTRL_ADDR, 1'b1, 32'h00000000, 32'h00000000, 1'b0);
        dev_en = 1'b0;
        // Each capability withdrawn in turn
        for (int k = 0; k < 3; k++) begin
            set_caps(k != 0, k != 1, k != 2);
            wr_flags($random(seed));
            set_caps(1'b1, 1'b1, 1'b1);
            wr_flags($random(seed));
        end
        apb(12'h00C, 1'b1, $random(seed), 32'h00000000, 1'b1);
        apb(12'h00C, 1'b0, 32'h00000000, 32'h00000000, 1'b1);
        apb(GROUP_FLAGS_ADDR, 1'b0, 32'h00000000, flags, 1'b0);
        results();
    end

    // Hang guard
    initial begin
        #500000;
        fail("timeout");
        results();
    end
endmodule // tb

// file: rtl/group_flags.sv
// Behaviour
// - Hold 8-bit allowed-token cap in bits 27:20.
// - Without token support, token fields are read-only and ignored.
// - Hold 8-bit reserved-token count in bits 15:8.
// - Bit 7 clear: device-wide ceiling not applied to group.
// - Bit 7 set: device-wide ceiling applied, group cap still applies.
// - Without global-ceiling support, bit 7 is reserved.
// - Selector one uses traffic class from bits 5:3.
// - Selector zero uses traffic class from bits 2:0.
// - Group fields writable only while device disabled.
// - Without configuration support, fields always read-only.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module group_flags
    import group_flags_pkg::*;
(
    input wire logic pclk, // Device clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic cap_config_support, // Configuration support capability
    input wire logic cap_tokens_support, // Bandwidth token capability
    input wire logic cap_global_support, // Global ceiling capability
    input wire logic tc_select, // Descriptor traffic-class selector
    output logic [2:0] traffic_class, // Class for current access
    output logic [7:0] tokens_allowed, // Group token cap, zero if unused
    output logic [7:0] tokens_reserved, // Group reservation, zero if unused
    output logic use_global_limit // Apply device-wide ceiling
);
    // ****************************************
    // Capability synchronisers
    // ****************************************
    logic [2:0] cap_meta_reg;
    logic [2:0] cap_reg;
    // Straps may come from another domain, so two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_meta_reg <= 3'h0;
            cap_reg <= 3'h0;
        end else begin
            cap_meta_reg <= {cap_global_support, cap_tokens_support, cap_config_support};
            cap_reg <= cap_meta_reg;
        end
    end
    logic cfg_ok;
    logic tok_ok;
    logic glb_ok;
    assign cfg_ok = cap_reg[0];
    assign tok_ok = cap_reg[1];
    assign glb_ok = cap_reg[2];

    // ****************************************
    // APB decode
    // ****************************************
    logic wr_en;
    logic rd_en;
    logic hit;
    assign hit = (paddr == GROUP_FLAGS_ADDR) || (paddr == CAP_STATUS_ADDR)
                 || (paddr == DEV_CTRL_ADDR);
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    // ****************************************
    // Storage
    // ****************************************
    logic dev_en_reg;
    logic [7:0] allow_reg;
    logic [7:0] resv_reg;
    logic global_reg;
    logic [2:0] tc1_reg;
    logic [2:0] tc0_reg;
    logic unlocked;
    // Fields lock while device runs or configuration is fixed
    // lock condition
    assign unlocked = !dev_en_reg && cfg_ok;

    // Device enable, a register of its own
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_en_reg <= DEV_EN_RESET;
        end else if (wr_en && paddr == DEV_CTRL_ADDR) begin
            dev_en_reg <= pwdata[0];
        end
    end

    // Token fields
    // token storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            allow_reg <= ALLOW_RESET;
            resv_reg <= RESV_RESET;
        end else if (wr_en && paddr == GROUP_FLAGS_ADDR && unlocked && tok_ok) begin
            allow_reg <= pwdata[ALLOW_LSB +: 8];
            resv_reg <= pwdata[RESV_LSB +: 8];
        end
    end

    // Global-limit selector
    // global bit storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_reg <= GLOBAL_RESET;
        end else if (wr_en && paddr == GROUP_FLAGS_ADDR && unlocked && glb_ok) begin
            global_reg <= pwdata[GLOBAL_BIT];
        end
    end

    // Traffic classes
    // class storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc1_reg <= TC_RESET;
            tc0_reg <= TC_RESET;
        end else if (wr_en && paddr == GROUP_FLAGS_ADDR && unlocked) begin
            tc1_reg <= pwdata[TC1_LSB +: 3];
            tc0_reg <= pwdata[TC0_LSB +: 3];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0] flags_view;
    always_comb begin
        flags_view = 32'h0;
        flags_view[ALLOW_LSB +: 8] = allow_reg;
        flags_view[RESV_LSB +: 8] = resv_reg;
        flags_view[GLOBAL_BIT] = global_reg;
        flags_view[TC1_LSB +: 3] = tc1_reg;
        flags_view[TC0_LSB +: 3] = tc0_reg;
        flags_view = flags_view & FLAGS_IMPL_MASK;
    end

    // Read data captured in setup, so every access ends with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            unique case (paddr)
                GROUP_FLAGS_ADDR: prdata <= flags_view;
                CAP_STATUS_ADDR: prdata <= {28'h0, unlocked, cap_reg};
                DEV_CTRL_ADDR: prdata <= {31'h0, dev_en_reg};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Ready from the first cycle of the access phase; unmapped address errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end

    // ****************************************
    // Consumer outputs
    // ****************************************
    // Unsupported fields are presented as zero, so users ignore them
    // output gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tokens_allowed <= 8'h00;
            tokens_reserved <= 8'h00;
            use_global_limit <= 1'b0;
        end else begin
            tokens_allowed <= tok_ok ? allow_reg : 8'h00;
            tokens_reserved <= tok_ok ? resv_reg : 8'h00;
            use_global_limit <= glb_ok && global_reg;
        end
    end

    // Class for the access; one cycle of latency from the selector
    // class select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            traffic_class <= TC_RESET;
        end else begin
            traffic_class <= tc_select ? tc1_reg : tc0_reg;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_class_pick;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> traffic_class == ($past(tc_select) ? $past(tc1_reg) : $past(tc0_reg));
    endproperty
    a_class_pick: assert property (p_class_pick) else $error("wrong class");

    property p_global;
        @(posedge pclk) disable iff (!presetn)
        (!global_reg || !glb_ok) |=> !use_global_limit;
    endproperty
    a_global: assert property (p_global) else $error("global limit leaked");

    property p_global_on;
        @(posedge pclk) disable iff (!presetn)
        (global_reg && glb_ok) |=> use_global_limit;
    endproperty
    a_global_on: assert property (p_global_on) else $error("global limit lost");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        !unlocked |=> $stable(allow_reg) && $stable(tc0_reg) && $stable(global_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("locked field changed");

    property p_tok_ro;
        @(posedge pclk) disable iff (!presetn)
        !tok_ok |=> $stable(resv_reg) && tokens_reserved == 8'h00;
    endproperty
    a_tok_ro: assert property (p_tok_ro) else $error("token field writable");

    property p_rsvd;
        @(posedge pclk) disable iff (!presetn)
        $past(rd_en) && $past(paddr) == GROUP_FLAGS_ADDR |-> prdata[19:16] == 4'h0 && !prdata[6];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

    property p_write_allow;
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == GROUP_FLAGS_ADDR && unlocked && tok_ok
            |=> allow_reg == $past(pwdata[27:20]);
    endproperty
    a_write_allow: assert property (p_write_allow) else $error("allowed not stored");

    property p_nocfg;
        @(posedge pclk) disable iff (!presetn)
        !cfg_ok |=> $stable(tc1_reg);
    endproperty
    a_nocfg: assert property (p_nocfg) else $error("config not locked");
endmodule // group_flags

// file: rtl/group_flags_pkg.sv
package group_flags_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] GROUP_FLAGS_ADDR = 12'h000;
    localparam logic [11:0] CAP_STATUS_ADDR = 12'h004;
    localparam logic [11:0] DEV_CTRL_ADDR = 12'h008;
    // ****************************************
    // Field positions of group_flags
    // ****************************************
    localparam int ALLOW_LSB = 20;
    localparam int RESV_LSB = 8;
    localparam int GLOBAL_BIT = 7;
    localparam int TC1_LSB = 3;
    localparam int TC0_LSB = 0;
    // Bits that software may ever hold
    localparam logic [31:0] FLAGS_IMPL_MASK = 32'h0FF0FFBF;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] ALLOW_RESET = 8'h00;
    localparam logic [7:0] RESV_RESET = 8'h00;
    localparam logic GLOBAL_RESET = 1'b0;
    localparam logic [2:0] TC_RESET = 3'h0;
    localparam logic DEV_EN_RESET = 1'b0;
endpackage
